// ### psoc_i2c_master_model.sv
// Purpose: Behavioural I2C bus master that programs the configuration bank
// Assumes: SCL half period of 5 system clocks; SDA pulled up on the board
// Notes:   Open-drain: the model only ever pulls SDA low
`timescale 1ns/1ps
module psoc_i2c_master_model (
	input  wire logic clk_in,     // System clock
	input  wire logic sda_in,     // Resolved SDA level
	output logic      scl_out,    // I2C clock
	output logic      sda_oe_out  // High pulls SDA low
);
	import psoc_pkg::*;

	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask

	task automatic bit_io(input logic b, output logic s);
		sda_oe_out = !b;
		cyc(4);
		scl_out = 1'b1;
		cyc(3);
		s = sda_in;
		cyc(2);
		scl_out = 1'b0;
		cyc(1);
	endtask

	task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
			output logic nine);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(last, nine);
	endtask

	// Also serves as repeated start: SDA released before SCL rises
	task automatic start();
		sda_oe_out = 1'b0;
		cyc(4);
		scl_out = 1'b1;
		cyc(5);
		sda_oe_out = 1'b1;
		cyc(5);
		scl_out = 1'b0;
		cyc(1);
	endtask

	task automatic stop();
		sda_oe_out = 1'b1;
		cyc(4);
		scl_out = 1'b1;
		cyc(5);
		sda_oe_out = 1'b0;
		cyc(5);
	endtask

	task automatic wr(input logic [7:0] ofs, input logic [7:0] data, output logic ok);
		logic [7:0] q;
		logic       a0;
		logic       a1;
		logic       a2;
		start();
		byte_io({I2C_SLAVE_ADDR, 1'b0}, 1'b1, q, a0);
		byte_io(ofs, 1'b1, q, a1);
		byte_io((ofs == 8'h01) ? (data & 8'hfd) : data, 1'b1, q, a2);
		stop();
		ok = !(a0 | a1 | a2);
	endtask

	task automatic rd(input logic [7:0] ofs, output logic [7:0] data);
		logic [7:0] q;
		logic       a;
		start();
		byte_io({I2C_SLAVE_ADDR, 1'b0}, 1'b1, q, a);
		byte_io(ofs, 1'b1, q, a);
		start();
		byte_io({I2C_SLAVE_ADDR, 1'b1}, 1'b1, q, a);
		byte_io(8'hff, 1'b1, data, a);
		stop();
	endtask
endmodule // psoc_i2c_master_model

// ### psoc_ov_timer.sv
// Purpose: Overvoltage qualification timer, millisecond resolution
// Assumes: arm_in stays high while the cell stays above the trip level
// Notes:   Dropping arm_in restarts the full delay
`timescale 1ns/1ps
module psoc_ov_timer #(
	parameter logic [14:0] CYC_PER_MS = 15'(psoc_pkg::CYC_PER_MS)
) (
	input  wire logic       clk_in,        // System clock
	input  wire logic       rst_n_in,      // Async reset, active low
	input  wire logic       arm_in,        // Cell above trip level
	input  wire logic [2:0] delay_code_in, // Delay code
	output logic            expired_out    // Delay elapsed while armed
);
	import psoc_pkg::*;

	psoc_tmr_t   t_reg;
	psoc_tmr_t   t_next;
	logic [11:0] target;

	assign target      = psoc_delay_ms(delay_code_in);
	assign expired_out = t_reg.expired;

	always_comb begin
		t_next = t_reg;
		if (!arm_in) begin
			t_next = '0;
		end else begin
			if (t_reg.div == CYC_PER_MS - 15'h0001) begin
				t_next.div = '0;
				if (t_reg.ms != 12'hfff)
					t_next.ms = t_reg.ms + 12'h001;
			end else begin
				t_next.div = t_reg.div + 15'h0001;
			end
			t_next.expired = (t_reg.ms >= target);
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in)
			t_reg <= '0;
		else
			t_reg <= t_next;
	end

	ov_delay_min_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		expired_out |-> $past(t_reg.ms) >= target)
		else $error("overvoltage delay expired early");

	ov_delay_reset_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		!arm_in |=> !expired_out && t_reg.ms == 12'h000)
		else $error("overvoltage delay not restarted");

endmodule // psoc_ov_timer

// ### psoc_pkg.sv
// Purpose: Shared constants, types and decoders for the protector configuration bank
// Assumes: 20 MHz system clock; I2C pins sampled as synchronous inputs
// Notes:   Register image stands for the non-volatile configuration store
package psoc_pkg;

	localparam int          CLK_HZ      = 32'h0131_2d00;   // 20 MHz
	localparam int          TICK_MS     = 1;               // Delay timer resolution, ms
	localparam int          CYC_PER_MS  = CLK_HZ / 1000 * TICK_MS;

	localparam logic [6:0]  I2C_SLAVE_ADDR = 7'h10;
	localparam logic [3:0]  BYTE_BITS      = 4'h8;

	localparam logic [7:0]  OFS_SYSTEM      = 8'h01;
	localparam logic [7:0]  OFS_OV_THRESH   = 8'h02;
	localparam logic [7:0]  OFS_OV_HYST_DLY = 8'h03;

	localparam logic [7:0]  RST_SYSTEM      = 8'h48;       // 8 cells, sensing on
	localparam logic [7:0]  RST_OV_THRESH   = 8'h38;
	localparam logic [7:0]  RST_OV_HYST_DLY = 8'h00;

	localparam logic [7:0]  MASK_SYSTEM      = 8'hfd;      // Reserved bits read zero
	localparam logic [7:0]  MASK_OV_THRESH   = 8'h3f;
	localparam logic [7:0]  MASK_OV_HYST_DLY = 8'hf7;

	localparam int          CELLS_MSB  = 7;
	localparam int          CELLS_LSB  = 5;
	localparam int          CTD_BIT    = 4;
	localparam int          TSENSE_BIT = 3;
	localparam int          OTREC_BIT  = 2;
	localparam int          RESV_BIT   = 1;
	localparam int          OCREC_BIT  = 0;
	localparam int          TRIP_MSB   = 5;
	localparam int          OVTS_BIT   = 7;
	localparam int          HYST_MSB   = 6;
	localparam int          HYST_LSB   = 4;
	localparam int          DLY_MSB    = 2;

	localparam logic [12:0] OV_TRIP_BASE_MV  = 13'h0af0;    // 2800 mV
	localparam logic [12:0] OV_TRIP_STEP_MV  = 13'h0019;    // 25 mV
	localparam logic [11:0] OV_DELAY_BASE_MS = 12'h01f4;    // 500 ms
	localparam logic [11:0] OV_DELAY_STEP_MS = 12'h00fa;    // 250 ms

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_PTR, ST_ACK_PTR,
		ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
	} psoc_i2c_st_t;

	typedef struct packed {
		logic charger_present;
		logic load_removed;
		logic overtemp_hot;
		logic overtemp_cooled;
		logic dsg_fault_event;
		logic cell_ov_above;
		logic cell_ov_below_hyst;
	} psoc_sense_t;

	typedef struct packed {
		logic overtemperature;
		logic overcurrent;
		logic overvoltage;
	} psoc_fault_t;

	typedef struct packed {
		logic [3:0]  cell_count;
		logic        cell_cfg_valid;
		logic        temp_sense_enable;
		logic [12:0] ov_trip_mv;
		logic [8:0]  ov_hyst_mv;
		logic [11:0] ov_delay_ms;
	} psoc_cfg_t;

	typedef struct packed {
		psoc_i2c_st_t st;
		logic [3:0]   bitcnt;
		logic [7:0]   shreg;
		logic         rw;
		logic [7:0]   ptr;
		logic         sda_oe;
		logic         scl_d;
		logic         sda_d;
		logic [7:0]   sys_conf;
		logic [7:0]   ov_thresh;
		logic [7:0]   ov_hyst_dly;
		psoc_fault_t  fault;
	} psoc_state_t;

	typedef struct packed {
		logic [14:0] div;
		logic [11:0] ms;
		logic        expired;
	} psoc_tmr_t;

	function automatic logic [3:0] psoc_cells(input logic [2:0] code);
		unique case (code)
			3'h2:    return 4'h8;
			3'h3:    return 4'h7;
			3'h4:    return 4'h6;
			3'h5:    return 4'h5;
			3'h6:    return 4'h4;
			default: return 4'h0;
		endcase
	endfunction

	function automatic logic [8:0] psoc_hyst_mv(input logic [2:0] code);
		unique case (code)
			3'h0: return 9'h12c;
			3'h1: return 9'h0fa;
			3'h2: return 9'h0c8;
			3'h3: return 9'h096;
			3'h4: return 9'h064;
			3'h5: return 9'h032;
			3'h6: return 9'h019;
			3'h7: return 9'h000;
		endcase
	endfunction

	function automatic logic [11:0] psoc_delay_ms(input logic [2:0] code);
		return OV_DELAY_BASE_MS + OV_DELAY_STEP_MS * 12'(code);
	endfunction

endpackage

// ### psoc_top.sv
// Purpose: Configuration bank and fault policy of a multi-cell protector
// Assumes: I2C pins synchronous to MCLK_IN; analog comparators outside
// Notes:   Register image stands for the non-volatile store
// Operation
// - Cell-count code 010..110 selects eight down to four cells; 000, 001, 111 invalid.
// - Charger-thermal-disable at 0 keeps thermal protection active in every mode.
// - Charger-thermal-disable at 1 clears thermal faults with charger; protects only without charger.
// - Charger-thermal-disable overrides overtemp recovery; charger clears faults regardless of load.
// - Overtemp fault leaves when cooled; recovery bit 1 also needs load removed.
// - Overvoltage code maps linearly, 2.800 V at 0x00 to 4.375 V at 0x3F.
// - Thermistor line charger control pulls the line low during overvoltage when set.
// - Hysteresis code gives 300, 250, 200, 150, 100, 50, 25, 0 mV.
// - Overvoltage delay is 0.50 s plus 0.25 s per code step before tripping.
// - All configuration settings live in the persistent register image.
`timescale 1ns/1ps
module psoc_top #(
	parameter logic [14:0] CYC_PER_MS = 15'(psoc_pkg::CYC_PER_MS)
) (
	input  wire logic              MCLK_IN,          // System clock, 20 MHz
	input  wire logic              RESET_N_IN,       // Async reset, active low
	input  wire logic              SCL_IN,           // I2C clock
	input  wire logic              SDA_IN,           // I2C data in
	output logic                   SDA_OUT,          // I2C data out, always low
	output logic                   SDA_OE_OUT,       // I2C data drive enable
	input  wire psoc_pkg::psoc_sense_t SENSE_IN,     // Comparator and pack sense
	output psoc_pkg::psoc_fault_t  FAULT_OUT,        // Latched faults
	output psoc_pkg::psoc_cfg_t    CFG_OUT,          // Decoded settings
	output logic                   THERM_LINE_OUT,   // Thermistor line out, low
	output logic                   THERM_LINE_OE_OUT // Thermistor line pull-low enable
);
	import psoc_pkg::*;

	psoc_state_t s_reg;
	psoc_state_t s_next;
	logic        scl_rise;
	logic        scl_fall;
	logic        i2c_start;
	logic        i2c_stop;
	logic [7:0]  rd_byte;
	logic        thermal_active;
	logic        ctd;
	logic        ov_expired;

	function automatic logic [7:0] reg_read(input psoc_state_t st, input logic [7:0] ofs);
		unique case (ofs)
			OFS_SYSTEM:      return st.sys_conf;
			OFS_OV_THRESH:   return st.ov_thresh;
			OFS_OV_HYST_DLY: return st.ov_hyst_dly;
			default:         return 8'h00;
		endcase
	endfunction

	assign scl_rise  = SCL_IN & ~s_reg.scl_d;
	assign scl_fall  = ~SCL_IN & s_reg.scl_d;
	assign i2c_start = s_reg.scl_d & SCL_IN & s_reg.sda_d & ~SDA_IN;
	assign i2c_stop  = s_reg.scl_d & SCL_IN & ~s_reg.sda_d & SDA_IN;
	assign rd_byte   = reg_read(s_reg, s_reg.ptr);
	assign ctd       = s_reg.sys_conf[CTD_BIT];

	// Sensing gated by enable; charger masks it only when disable bit set
	assign thermal_active = s_reg.sys_conf[TSENSE_BIT]
		& (~ctd | ~SENSE_IN.charger_present);

	psoc_ov_timer #(
		.CYC_PER_MS (CYC_PER_MS)
	) u_ov_timer (
		.clk_in        (MCLK_IN),
		.rst_n_in      (RESET_N_IN),
		.arm_in        (SENSE_IN.cell_ov_above & ~s_reg.fault.overvoltage),
		.delay_code_in (s_reg.ov_hyst_dly[DLY_MSB:0]),
		.expired_out   (ov_expired)
	);

	always_comb begin
		s_next       = s_reg;
		s_next.scl_d = SCL_IN;
		s_next.sda_d = SDA_IN;
		if (i2c_start) begin
			s_next.st     = ST_ADDR;
			s_next.bitcnt = 4'h0;
			s_next.sda_oe = 1'b0;
		end else if (i2c_stop) begin
			s_next.st     = ST_IDLE;
			s_next.sda_oe = 1'b0;
		end else if (scl_rise) begin
			unique case (s_reg.st)
				ST_ADDR, ST_PTR, ST_WR: begin
					s_next.shreg  = {s_reg.shreg[6:0], SDA_IN};
					s_next.bitcnt = s_reg.bitcnt + 4'h1;
				end
				ST_RD: s_next.bitcnt = s_reg.bitcnt + 4'h1;
				ST_ACK_RD: begin
					if (SDA_IN)
						s_next.st = ST_IDLE;
				end
				ST_IDLE, ST_ACK_ADDR, ST_ACK_PTR, ST_ACK_WR: ;
			endcase
		end else if (scl_fall) begin
			unique case (s_reg.st)
				ST_ADDR: begin
					if (s_reg.bitcnt == BYTE_BITS) begin
						if (s_reg.shreg[7:1] == I2C_SLAVE_ADDR) begin
							s_next.st     = ST_ACK_ADDR;
							s_next.rw     = s_reg.shreg[0];
							s_next.sda_oe = 1'b1;
						end else begin
							s_next.st = ST_IDLE;
						end
					end
				end
				ST_ACK_ADDR: begin
					s_next.bitcnt = 4'h0;
					if (s_reg.rw) begin
						s_next.st     = ST_RD;
						s_next.shreg  = rd_byte;
						s_next.sda_oe = ~rd_byte[7];
					end else begin
						s_next.st     = ST_PTR;
						s_next.sda_oe = 1'b0;
					end
				end
				ST_PTR: begin
					if (s_reg.bitcnt == BYTE_BITS) begin
						s_next.ptr    = s_reg.shreg;
						s_next.st     = ST_ACK_PTR;
						s_next.sda_oe = 1'b1;
					end
				end
				ST_ACK_PTR, ST_ACK_WR: begin
					s_next.st     = ST_WR;
					s_next.bitcnt = 4'h0;
					s_next.sda_oe = 1'b0;
				end
				ST_WR: begin
					if (s_reg.bitcnt == BYTE_BITS) begin
						// Same location on every data byte, pointer never moves
						if (s_reg.ptr == OFS_SYSTEM)
							s_next.sys_conf = s_reg.shreg & MASK_SYSTEM;
						if (s_reg.ptr == OFS_OV_THRESH)
							s_next.ov_thresh = s_reg.shreg & MASK_OV_THRESH;
						if (s_reg.ptr == OFS_OV_HYST_DLY)
							s_next.ov_hyst_dly = s_reg.shreg & MASK_OV_HYST_DLY;
						s_next.st     = ST_ACK_WR;
						s_next.sda_oe = 1'b1;
					end
				end
				ST_RD: begin
					if (s_reg.bitcnt == BYTE_BITS) begin
						s_next.st     = ST_ACK_RD;
						s_next.sda_oe = 1'b0;
					end else begin
						s_next.sda_oe = ~s_reg.shreg[3'h7 - s_reg.bitcnt[2:0]];
					end
				end
				ST_ACK_RD: begin
					s_next.st     = ST_RD;
					s_next.bitcnt = 4'h0;
					s_next.shreg  = rd_byte;
					s_next.sda_oe = ~rd_byte[7];
				end
				ST_IDLE: ;
			endcase
		end

		// Overtemperature: sensing-off clear first, then charger clear, then cooled recovery; set wins
		if (thermal_active && SENSE_IN.overtemp_hot)
			s_next.fault.overtemperature = 1'b1;
		else if (!s_reg.sys_conf[TSENSE_BIT])
			s_next.fault.overtemperature = 1'b0;
		else if (ctd && SENSE_IN.charger_present)
			s_next.fault.overtemperature = 1'b0;
		else if (SENSE_IN.overtemp_cooled
			&& (!s_reg.sys_conf[OTREC_BIT] || SENSE_IN.load_removed))
			s_next.fault.overtemperature = 1'b0;

		// Discharge overcurrent or short circuit; set wins
		if (SENSE_IN.dsg_fault_event)
			s_next.fault.overcurrent = 1'b1;
		else if (SENSE_IN.load_removed
			&& (!s_reg.sys_conf[OCREC_BIT] || SENSE_IN.charger_present))
			s_next.fault.overcurrent = 1'b0;

		if (ov_expired)
			s_next.fault.overvoltage = 1'b1;
		else if (SENSE_IN.cell_ov_below_hyst)
			s_next.fault.overvoltage = 1'b0;
	end

	always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			s_reg             <= '0;
			s_reg.st          <= ST_IDLE;
			s_reg.scl_d       <= 1'b1;
			s_reg.sda_d       <= 1'b1;
			s_reg.sys_conf    <= RST_SYSTEM;
			s_reg.ov_thresh   <= RST_OV_THRESH;
			s_reg.ov_hyst_dly <= RST_OV_HYST_DLY;
		end else begin
			s_reg <= s_next;
		end
	end

	assign SDA_OUT    = 1'b0;
	assign SDA_OE_OUT = s_reg.sda_oe;
	assign FAULT_OUT  = s_reg.fault;

	assign CFG_OUT.cell_count        = psoc_cells(s_reg.sys_conf[CELLS_MSB:CELLS_LSB]);
	assign CFG_OUT.cell_cfg_valid    = (CFG_OUT.cell_count != 4'h0);
	assign CFG_OUT.temp_sense_enable = s_reg.sys_conf[TSENSE_BIT];
	assign CFG_OUT.ov_trip_mv        = OV_TRIP_BASE_MV
		+ OV_TRIP_STEP_MV * 13'(s_reg.ov_thresh[TRIP_MSB:0]);
	assign CFG_OUT.ov_hyst_mv        = psoc_hyst_mv(s_reg.ov_hyst_dly[HYST_MSB:HYST_LSB]);
	assign CFG_OUT.ov_delay_ms       = psoc_delay_ms(s_reg.ov_hyst_dly[DLY_MSB:0]);

	assign THERM_LINE_OUT    = 1'b0;
	assign THERM_LINE_OE_OUT = s_reg.fault.overvoltage & s_reg.ov_hyst_dly[OVTS_BIT];

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);

	sequence temp_fault_held_s;
		s_reg.fault.overtemperature && s_reg.sys_conf[TSENSE_BIT] && !ctd
			&& s_reg.sys_conf[OTREC_BIT] && !SENSE_IN.load_removed;
	endsequence

	sequence charger_in_s;
		s_reg.sys_conf[TSENSE_BIT] && ctd && SENSE_IN.charger_present;
	endsequence

	cell_decode_a: assert property (
		CFG_OUT.cell_cfg_valid == (s_reg.sys_conf[CELLS_MSB:CELLS_LSB] inside {[3'h2:3'h6]})
		&& (!CFG_OUT.cell_cfg_valid
			|| CFG_OUT.cell_count == 4'h8 - 4'(s_reg.sys_conf[CELLS_MSB:CELLS_LSB]) + 4'h2))
		else $error("cell count decode wrong");

	thermal_always_a: assert property (
		s_reg.sys_conf[TSENSE_BIT] && !ctd && SENSE_IN.overtemp_hot
		|=> s_reg.fault.overtemperature)
		else $error("thermal fault missed");

	charger_clear_a: assert property (
		charger_in_s ##1 charger_in_s |-> !s_reg.fault.overtemperature)
		else $error("thermal fault kept with charger");

	temp_recover_wait_a: assert property (
		temp_fault_held_s and !SENSE_IN.charger_present |=> s_reg.fault.overtemperature)
		else $error("overtemperature left before load removal");

	oc_recover_a: assert property (
		s_reg.fault.overcurrent && s_reg.sys_conf[OCREC_BIT] && !SENSE_IN.charger_present
		|=> s_reg.fault.overcurrent)
		else $error("overcurrent released without charger");

	reserved_zero_a: assert property (
		!s_reg.sys_conf[RESV_BIT] && s_reg.ov_thresh[7:6] == 2'b00 && !s_reg.ov_hyst_dly[3])
		else $error("reserved bit stored");

	ov_trip_range_a: assert property (
		CFG_OUT.ov_trip_mv >= 13'h0af0 && CFG_OUT.ov_trip_mv <= 13'h1117
		&& (s_reg.ov_thresh[TRIP_MSB:0] != 6'h3f || CFG_OUT.ov_trip_mv == 13'h1117))
		else $error("overvoltage trip level off range");

	therm_line_a: assert property (
		$rose(s_reg.fault.overvoltage) && s_reg.ov_hyst_dly[OVTS_BIT] |-> THERM_LINE_OE_OUT
		##1 (THERM_LINE_OE_OUT == (s_reg.fault.overvoltage && s_reg.ov_hyst_dly[OVTS_BIT])))
		else $error("thermistor line not pulled on overvoltage");

	hyst_ends_a: assert property (
		(s_reg.ov_hyst_dly[HYST_MSB:HYST_LSB] == 3'h7 |-> CFG_OUT.ov_hyst_mv == 9'h000)
		and (s_reg.ov_hyst_dly[HYST_MSB:HYST_LSB] == 3'h0 |-> CFG_OUT.ov_hyst_mv == 9'h12c))
		else $error("hysteresis decode wrong");

endmodule // psoc_top

// ### tb.sv
// Purpose: Self-checking bench for the protector configuration bank
// Assumes: Timer shortened to 4 cycles per ms
// Notes:   All stimulus changes 2 ns after the rising clock edge
`timescale 1ns/1ps
module tb;
	import psoc_pkg::*;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic        scl;
	logic        m_sda_oe;
	wire logic   sda_wire;
	logic        sda_out;
	logic        sda_oe;
	psoc_sense_t sense = '0;
	psoc_fault_t fault;
	psoc_cfg_t   cfg;
	logic        therm;
	logic        therm_oe;
	int          fail_count = 0;
	int          checks_done = 0;
	int          cycles = 0;
	logic [7:0]  q;
	logic        ok;
	logic [3:0]  cells_exp [8] = '{4'h0, 4'h0, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0};
	logic [8:0]  hyst_exp [8] = '{9'h12c, 9'h0fa, 9'h0c8, 9'h096, 9'h064, 9'h032, 9'h019, 9'h000};
	logic [5:0]  ovt_codes [4] = '{6'h00, 6'h01, 6'h20, 6'h3f};

	always #25 mclk = ~mclk;
	// Pulled up; the device drives its data level while enabled
	assign sda_wire = (sda_oe ? sda_out : 1'b1) & !m_sda_oe;

	psoc_top #(.CYC_PER_MS(15'h0004)) DUT (
		.MCLK_IN(mclk), .RESET_N_IN(rst_n), .SCL_IN(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .SENSE_IN(sense), .FAULT_OUT(fault),
		.CFG_OUT(cfg), .THERM_LINE_OUT(therm), .THERM_LINE_OE_OUT(therm_oe)
	);

	psoc_i2c_master_model M (
		.clk_in(mclk), .sda_in(sda_wire), .scl_out(scl), .sda_oe_out(m_sda_oe)
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wreg(input logic [7:0] ofs, input logic [7:0] d);
		M.wr(ofs, d, ok);
		chk("write ack", ok, 1'b1);
	endtask

	task automatic rreg(input logic [7:0] ofs, input logic [7:0] exp);
		M.rd(ofs, q);
		chk("read data", q, exp);
	endtask

	task automatic sf(input logic [6:0] s, input logic [2:0] f);
		sense = s;
		cyc(3);
		chk("faults", fault, f);
	endtask

	task automatic ov_run(input int wait_n, input logic th);
		sense = 7'h02;
		cyc(wait_n - 40);
		chk("ov early", fault, 3'h0);
		cyc(100);
		chk("ov late", fault, 3'h1);
		chk("therm pull", therm_oe, th);
		chk("therm level", therm, 1'b0);
		sf(7'h01, 3'h0);
		chk("therm off", therm_oe, 1'b0);
	endtask

	task automatic finish_test();
		$display("checks_done %0d fail_count %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			fail_count++;
			finish_test();
		end
	end

	initial begin
		cyc(4);
		rst_n = 1'b1;
		cyc(2);
		chk("cells", cfg.cell_count, 4'h8);
		chk("sense en", cfg.temp_sense_enable, 1'b1);
		chk("trip", cfg.ov_trip_mv, 13'h1068);
		chk("hyst", cfg.ov_hyst_mv, 9'h12c);
		chk("delay", cfg.ov_delay_ms, 12'h01f4);
		rreg(8'h01, 8'h48);
		rreg(8'h02, 8'h38);
		rreg(8'h03, 8'h00);
		rreg(8'h05, 8'h00);
		M.start();
		M.byte_io(8'h42, 1'b1, q, ok);
		M.stop();
		chk("foreign addr nack", ok, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wreg(8'h01, {3'(i), 5'h08});
			chk("cells", cfg.cell_count, cells_exp[i]);
			chk("valid", cfg.cell_cfg_valid, cells_exp[i] != 4'h0);
		end
		for (int i = 0; i < 4; i++) begin
			wreg(8'h02, {2'h3, ovt_codes[i]});
			chk("trip", cfg.ov_trip_mv, 13'h0af0 + 13'h0019 * 13'(ovt_codes[i]));
			rreg(8'h02, {2'h0, ovt_codes[i]});
		end
		for (int i = 0; i < 8; i++) begin
			wreg(8'h03, {1'b0, 3'(i), 1'b0, 3'(i)});
			chk("hyst", cfg.ov_hyst_mv, hyst_exp[i]);
			chk("delay", cfg.ov_delay_ms, 12'h01f4 + 12'h00fa * 12'(i));
		end
		wreg(8'h01, 8'h48);
		sf(7'h50, 3'h4);
		sf(7'h40, 3'h4);
		sf(7'h08, 3'h0);
		sf(7'h04, 3'h2);
		sf(7'h00, 3'h2);
		sf(7'h20, 3'h0);
		wreg(8'h01, 8'h4d);
		sf(7'h14, 3'h6);
		sf(7'h08, 3'h6);
		sf(7'h28, 3'h2);
		sf(7'h60, 3'h0);
		wreg(8'h01, 8'h5c);
		sf(7'h50, 3'h0);
		sf(7'h10, 3'h4);
		sf(7'h40, 3'h0);
		wreg(8'h01, 8'h40);
		chk("sense en", cfg.temp_sense_enable, 1'b0);
		sf(7'h10, 3'h0);
		sf(7'h00, 3'h0);
		wreg(8'h03, 8'h81);
		ov_run(3000, 1'b1);
		wreg(8'h03, 8'h00);
		ov_run(2000, 1'b0);
		finish_test();
	end
endmodule // tb
